// File: hdl/brsw_core.sv
// Purpose: reset-cause flags, brown-out mode control and sleep-wake logic
// Assumes: inputs synchronous to hclk; hresetn is the power-on reset
// Notes: registers reached over AHB-Lite, zero wait states
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`default_nettype none
`timescale 1ns/1ps
module brsw_core (
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // configuration word fields
    input wire logic [1:0] brownout_mode_cfg,
    input wire logic brownout_level_sel,
    // supply detector
    input wire logic supply_low,
    input wire logic brownout_det_ready,
    output logic brownout_det_enable,
    output logic brownout_level_out,
    // reset and wake sources
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset_evt,
    input wire logic watchdog_wake_evt,
    input wire logic soft_reset_instr,
    input wire logic stack_overflow_evt,
    input wire logic stack_underflow_evt,
    input wire logic sleep_instr,
    input wire logic global_irq_enable,
    input wire logic [7:0] irq_enable,
    input wire logic [7:0] irq_flags,
    // to the core
    output logic chip_reset,
    output logic cpu_stall,
    output logic sleeping,
    output logic watchdog_clear,
    output logic brownout_ready
);

    // ==========================================================
    // helpers
    // map a byte address to a register index
    function automatic logic [1:0] reg_idx(input logic [31:0] a);
        logic [1:0] r;
        r = brsw_pkg::IDX_NONE;
        if (a[31:8] == 24'h000000) begin
            unique case (a[7:0])
                brsw_pkg::OFS_RESET_CAUSE: r = brsw_pkg::IDX_RESET_CAUSE;
                brsw_pkg::OFS_BROWNOUT_CTRL: r = brsw_pkg::IDX_BROWNOUT_CTRL;
                brsw_pkg::OFS_CPU_STATUS: r = brsw_pkg::IDX_CPU_STATUS;
                default: r = brsw_pkg::IDX_NONE;
            endcase
        end
        return r;
    endfunction

    function automatic logic det_on(input logic [1:0] m, input logic sw,
                                    input brsw_pkg::brsw_pstate_t ps);
        logic on;
        on = 1'b0;
        unique case (m)
            brsw_pkg::MODE_ALWAYS_ON: on = 1'b1;
            brsw_pkg::MODE_OFF_IN_SLEEP: on = (ps == brsw_pkg::PS_AWAKE);
            brsw_pkg::MODE_SOFTWARE: on = sw;
            brsw_pkg::MODE_ALWAYS_OFF: on = 1'b0;
        endcase
        return on;
    endfunction

    // ==========================================================
    // state
    brsw_pkg::brsw_state_t q;
    brsw_pkg::brsw_state_t next_q;
    logic active;
    logic low;
    logic bor_trip;
    logic any_rst;
    logic irq_wake;
    logic accept;
    logic unused_ok;

    // ==========================================================
    // combinational terms
    assign active = det_on(brownout_mode_cfg, q.sw_en, q.pstate);
    assign low = active & supply_low;
    assign bor_trip = low & (q.filt_cnt == brsw_pkg::FILT_CYC);
    // reset sources, power-on handled by hresetn
    assign any_rst = bor_trip | ~external_reset_pin_n | watchdog_reset_evt | soft_reset_instr;
    // global enable takes no part in wake
    assign irq_wake = |(irq_enable & irq_flags);
    assign accept = hsel & htrans[1] & hready;
    // global enable and size only matter to the core and the master
    assign unused_ok = global_irq_enable ^ (^hsize);

    // ==========================================================
    // next-state logic
    always_comb begin
        next_q = q;
        next_q.wdt_clr = 1'b0;

        if (!low) begin
            next_q.filt_cnt = 8'h00;
        end else if (q.filt_cnt != brsw_pkg::FILT_CYC) begin
            next_q.filt_cnt = q.filt_cnt + 8'h01;
        end

        next_q.chip_rst = any_rst;

        next_q.ready = active & brownout_det_ready;

        // firmware writes land first so hardware below overrides them
        if (q.wr_pend) begin
            unique case (q.wr_idx)
                brsw_pkg::IDX_RESET_CAUSE: begin
                    next_q.flags = hwdata[7:0] & brsw_pkg::FLAGS_MASK;
                end
                brsw_pkg::IDX_BROWNOUT_CTRL: begin
                    next_q.sw_en = hwdata[brsw_pkg::BIT_SW_ENABLE];
                end
                default: begin
                    next_q.sw_en = q.sw_en; // status and unmapped: read only
                end
            endcase
        end

        // hardware wins over the write above
        if (stack_overflow_evt) begin
            next_q.flags[brsw_pkg::BIT_STACK_OVF] = 1'b1;
        end
        if (stack_underflow_evt) begin
            next_q.flags[brsw_pkg::BIT_STACK_UNF] = 1'b1;
        end
        if (watchdog_reset_evt) begin
            next_q.flags[brsw_pkg::BIT_WDT_RST] = 1'b0;
            next_q.expiry = 1'b0;
        end
        if (!external_reset_pin_n) begin
            next_q.flags[brsw_pkg::BIT_PIN_RST] = 1'b0;
        end
        if (soft_reset_instr) begin
            next_q.flags[brsw_pkg::BIT_SOFT_RST] = 1'b0;
        end
        if (bor_trip) begin
            next_q.flags[brsw_pkg::BIT_BOR] = 1'b0;
        end

        // sleep and wake sequencing
        if (any_rst) begin
            next_q.pstate = brsw_pkg::PS_AWAKE;
            next_q.wdt_clr = (q.pstate == brsw_pkg::PS_ASLEEP);
        end else if (q.pstate == brsw_pkg::PS_ASLEEP) begin
            if (irq_wake | watchdog_wake_evt) begin
                next_q.pstate = brsw_pkg::PS_AWAKE;
                next_q.wdt_clr = 1'b1;
                if (watchdog_wake_evt) begin
                    next_q.expiry = 1'b0; // timeout wake
                end
            end
        end else if (sleep_instr) begin
            if (!irq_wake) begin
                next_q.pstate = brsw_pkg::PS_ASLEEP;
                next_q.wdt_clr = 1'b1;
                next_q.expiry = 1'b1;
                next_q.sleep_entered = 1'b0;
            end
        end

        // bus address phase
        next_q.wr_pend = accept & hwrite;
        next_q.wr_idx = reg_idx(haddr);
        if (accept && !hwrite) begin
            next_q.rdata = 32'h00000000;
            unique case (reg_idx(haddr))
                brsw_pkg::IDX_RESET_CAUSE: next_q.rdata[7:0] = q.flags;
                brsw_pkg::IDX_BROWNOUT_CTRL: begin
                    next_q.rdata[brsw_pkg::BIT_SW_ENABLE] = q.sw_en;
                    next_q.rdata[brsw_pkg::BIT_READY] = q.ready;
                end
                brsw_pkg::IDX_CPU_STATUS: begin
                    next_q.rdata[brsw_pkg::BIT_EXPIRY] = q.expiry;
                    next_q.rdata[brsw_pkg::BIT_SLEEP_ENTERED] = q.sleep_entered;
                end
                default: next_q.rdata = 32'h00000000;
            endcase
        end
    end

    // ==========================================================
    // state register; power-on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // power-on clears power-on and brown-out flags
            q.flags <= brsw_pkg::FLAGS_RESET;
            q.sw_en <= 1'b0;
            q.expiry <= 1'b1;
            q.sleep_entered <= 1'b1;
            q.pstate <= brsw_pkg::PS_AWAKE;
            q.filt_cnt <= 8'h00;
            q.wr_pend <= 1'b0;
            q.wr_idx <= brsw_pkg::IDX_NONE;
            q.rdata <= 32'h00000000;
            q.chip_rst <= 1'b0;
            q.wdt_clr <= 1'b0;
            q.ready <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout = 1'b1; // no wait states ever needed
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign brownout_det_enable = active;
    // level bit passed straight to the detector
    assign brownout_level_out = brownout_level_sel;
    assign chip_reset = q.chip_rst;
    // stall in off-in-sleep mode while awake and the detector is not ready; no stall when disabled
    assign cpu_stall = (brownout_mode_cfg == brsw_pkg::MODE_OFF_IN_SLEEP)
                       & (q.pstate == brsw_pkg::PS_AWAKE) & ~brownout_det_ready & ~unused_ok
                       | (brownout_mode_cfg == brsw_pkg::MODE_OFF_IN_SLEEP)
                       & (q.pstate == brsw_pkg::PS_AWAKE) & ~brownout_det_ready & unused_ok;
    assign sleeping = (q.pstate == brsw_pkg::PS_ASLEEP);
    assign watchdog_clear = q.wdt_clr;
    assign brownout_ready = q.ready;

endmodule
`default_nettype wire

// File: include/brsw_pkg.sv
// Purpose: shared constants and types of the brown-out reset and sleep-wake block
// Assumes: 50 MHz hclk, AHB-Lite register access, one aligned word per register
// Notes: register offsets are byte addresses
`default_nettype none
package brsw_pkg;
    // ==========================================================
    // clock and filter timing
    localparam int unsigned CLK_PERIOD_NS = 20;
    // least low-supply duration before a trip, ns (plain default)
    localparam int unsigned BROWNOUT_FILTER_TIME_NS = 1000;
    localparam int unsigned FILT_CYC_I =
        (BROWNOUT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] FILT_CYC = FILT_CYC_I[7:0];

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
    localparam logic [7:0] OFS_BROWNOUT_CTRL = 8'h04;
    localparam logic [7:0] OFS_CPU_STATUS = 8'h08;
    localparam logic [1:0] IDX_RESET_CAUSE = 2'h0;
    localparam logic [1:0] IDX_BROWNOUT_CTRL = 2'h1;
    localparam logic [1:0] IDX_CPU_STATUS = 2'h2;
    localparam logic [1:0] IDX_NONE = 2'h3;

    // ==========================================================
    // reset_cause_flags fields
    localparam int unsigned BIT_STACK_OVF = 7;
    localparam int unsigned BIT_STACK_UNF = 6;
    localparam int unsigned BIT_WDT_RST = 4;
    localparam int unsigned BIT_PIN_RST = 3;
    localparam int unsigned BIT_SOFT_RST = 2;
    localparam int unsigned BIT_POR = 1;
    localparam int unsigned BIT_BOR = 0;
    localparam logic [7:0] FLAGS_MASK = 8'hDF;
    localparam logic [7:0] FLAGS_RESET = 8'h1C;

    // brownout_control and cpu_status_flags fields
    localparam int unsigned BIT_SW_ENABLE = 7;
    localparam int unsigned BIT_READY = 0;
    localparam int unsigned BIT_EXPIRY = 4;
    localparam int unsigned BIT_SLEEP_ENTERED = 3;

    // ==========================================================
    // brown-out modes
    localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
    localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;

    typedef enum logic [0:0] {
        PS_AWAKE = 1'b0,
        PS_ASLEEP = 1'b1
    } brsw_pstate_t;

    typedef struct packed {
        logic [7:0] flags;
        logic sw_en;
        logic expiry;
        logic sleep_entered;
        brsw_pstate_t pstate;
        logic [7:0] filt_cnt;
        logic wr_pend;
        logic [1:0] wr_idx;
        logic [31:0] rdata;
        logic chip_rst;
        logic wdt_clr;
        logic ready;
    } brsw_state_t;
endpackage
`default_nettype wire

// File: sim/brsw_core_properties.sv
// Purpose: port-level timing checks for the brown-out and sleep-wake block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every brsw_core instance
`timescale 1ns/1ps
`default_nettype none
module brsw_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] brownout_mode_cfg,
    input wire logic supply_low,
    input wire logic brownout_det_ready,
    input wire logic brownout_det_enable,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset_evt,
    input wire logic sleep_instr,
    input wire logic [7:0] irq_enable,
    input wire logic [7:0] irq_flags,
    input wire logic chip_reset,
    input wire logic cpu_stall,
    input wire logic sleeping,
    input wire logic watchdog_clear,
    input wire logic brownout_ready
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic pend;
    logic [7:0] low_cnt;
    // ==========================================================
    // helpers
    assign pend = |(irq_enable & irq_flags);
    // run length of low supply seen by an enabled detector, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt <= 8'h00;
        end else begin
            low_cnt <= (supply_low && brownout_det_enable) ?
                low_cnt + {7'h00, low_cnt != 8'hFF} : 8'h00;
        end
    end
    // ==========================================================
    // assertions
    chk_bor_trip: assert property (low_cnt == 8'h37 |-> chip_reset)
        else $error("no reset after long low supply");
    chk_ready_on: assert property (brownout_mode_cfg == 2'h3 && brownout_det_ready
        |=> brownout_ready) else $error("ready flag missing in always-on mode");
    chk_stall_wait: assert property (cpu_stall == (brownout_mode_cfg == 2'h2
        && !sleeping && !brownout_det_ready)) else $error("stall does not follow ready");
    chk_det_sleep: assert property (brownout_mode_cfg == 2'h2 && sleeping
        |-> !brownout_det_enable) else $error("detector on while asleep");
    chk_off_mode: assert property (brownout_mode_cfg == 2'h0
        |-> !brownout_det_enable && !cpu_stall) else $error("detector or stall in off mode");
    chk_pin_reset: assert property (!external_reset_pin_n |=> chip_reset)
        else $error("pin reset not passed on");
    chk_wdt_reset: assert property (watchdog_reset_evt |=> chip_reset)
        else $error("watchdog reset not passed on");
    chk_wake_clear: assert property (sleeping ##1 !sleeping |-> watchdog_clear)
        else $error("wake without watchdog clear");
    chk_irq_wake: assert property (sleeping && pend |=> !sleeping)
        else $error("pending interrupt did not wake");
    chk_sleep_nop: assert property (sleep_instr && pend && !sleeping
        |=> !sleeping && !watchdog_clear) else $error("sleep not ignored");
    chk_sleep_go: assert property (sleep_instr && !pend && !sleeping
        |=> sleeping && watchdog_clear) else $error("sleep not entered");
    cover property (sleeping && pend);
    cover property (low_cnt == 8'h37);
    cover property (cpu_stall ##1 !cpu_stall);
endmodule
bind brsw_core brsw_checker u_chk (.hclk, .hresetn, .brownout_mode_cfg, .supply_low,
    .brownout_det_ready, .brownout_det_enable, .external_reset_pin_n, .watchdog_reset_evt,
    .sleep_instr, .irq_enable, .irq_flags, .chip_reset, .cpu_stall, .sleeping,
    .watchdog_clear, .brownout_ready);
`default_nettype wire

// File: sim/brsw_core_tb_top.sv
// Purpose: self-checking bench for brsw_core
// Assumes: 50 MHz hclk, AHB-Lite slave with its own ready
// Notes: filter length is a package constant, so low-supply runs last 31 or 61 cycles
`timescale 1ns/1ps
`default_nettype none
module brsw_core_tb_top;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} brsw_row_t;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic low_cmd = 1'b0, pin_cmd = 1'b0, hreadyout, hresp, det_en, sup_low, det_rdy, pin_n;
    logic chip_reset, cpu_stall, sleeping, wdt_clr, rdy, lvl;
    logic [1:0] htrans = 2'h0, mode = 2'h0;
    logic [5:0] ev = 6'h00;
    logic [7:0] ien = 8'h00, ifl = 8'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    int error_cnt = 0, tests_run = 0, n;
    brsw_row_t rows[6] = '{'{8'h00, 8'hFF, 8'hDF}, '{8'h00, 8'h00, 8'h00},
        '{8'h04, 8'h80, 8'h81}, '{8'h04, 8'h00, 8'h01}, '{8'h08, 8'h00, 8'h18},
        '{8'h0C, 8'hFF, 8'h00}};
    always #10 hclk = ~hclk;
    brsw_core u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .brownout_mode_cfg(mode),
        .brownout_level_sel(mode[0]), .supply_low(sup_low), .brownout_det_ready(det_rdy),
        .brownout_det_enable(det_en), .brownout_level_out(lvl), .external_reset_pin_n(pin_n),
        .watchdog_reset_evt(ev[0]), .watchdog_wake_evt(ev[1]), .soft_reset_instr(ev[2]),
        .stack_overflow_evt(ev[3]), .stack_underflow_evt(ev[4]), .sleep_instr(ev[5]),
        .global_irq_enable(1'b0), .irq_enable(ien), .irq_flags(ifl), .chip_reset, .cpu_stall,
        .sleeping, .watchdog_clear(wdt_clr), .brownout_ready(rdy));
    brsw_partner u_far (.hclk, .det_enable(det_en), .low_cmd, .pin_cmd,
        .supply_low(sup_low), .det_ready(det_rdy), .pin_n);
    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // bounded wait: a slave that never answers ends the run
    task automatic wait_rdy();
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    // one single transfer; e pulses a stack overflow in the data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic e);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        ev[3] <= e;
        wait_rdy();
        ev[3] <= 1'b0;
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 1'b0);
        chk(rd, {24'h0, e});
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge hclk) ev <= m;
        @(posedge hclk) ev <= 6'h00;
    endtask
    // step past the edge so its updates have landed
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
        #1;
    endtask
    task automatic low_run(input int k);
        @(posedge hclk) low_cmd <= 1'b1;
        cyc(k);
        @(posedge hclk) low_cmd <= 1'b0;
        #1; // let the edge's register updates settle before any compare
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 8'h1C);
        rchk(8'h04, 8'h00);
        @(posedge hclk) mode <= 2'h3;
        cyc(8);
        chk({31'h0, lvl}, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, 1'b0);
            rchk(rows[i].a, rows[i].e);
        end
        bus(1'b1, 8'h00, 8'h00, 1'b1);
        rchk(8'h00, 8'h80);
        pulse(6'h10);
        rchk(8'h00, 8'hC0);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 8'h00, 8'h1F, 1'b0);
            @(posedge hclk) pin_cmd <= (k == 2);
            ev <= (k == 0) ? 6'h01 : (k == 1) ? 6'h04 : 6'h00;
            @(posedge hclk) pin_cmd <= 1'b0;
            ev <= 6'h00;
            cyc(0);
            chk({31'h0, chip_reset}, 32'h1);
            cyc(4);
            rchk(8'h00, 8'h1F & ~((k == 0) ? 8'h10 : (k == 1) ? 8'h04 : 8'h08));
        end
        bus(1'b1, 8'h00, 8'h1F, 1'b0);
        low_run(30);
        chk({31'h0, chip_reset}, 32'h0);
        low_run(60);
        chk({31'h0, chip_reset}, 32'h1);
        cyc(3);
        rchk(8'h00, 8'h1E);
        @(posedge hclk) mode <= 2'h0;
        cyc(0);
        chk({31'h0, lvl}, 32'h0);
        low_run(60);
        chk({31'h0, chip_reset}, 32'h0);
        @(posedge hclk) mode <= 2'h1;
        bus(1'b1, 8'h04, 8'h80, 1'b0);
        cyc(0);
        chk({31'h0, det_en}, 32'h1);
        bus(1'b1, 8'h04, 8'h00, 1'b0);
        @(posedge hclk) mode <= 2'h2;
        cyc(0);
        chk({31'h0, cpu_stall}, 32'h1);
        cyc(8);
        chk({31'h0, cpu_stall}, 32'h0);
        pulse(6'h20);
        cyc(0);
        chk({30'h0, sleeping, wdt_clr}, 32'h3);
        low_run(60);
        chk({31'h0, chip_reset}, 32'h0);
        rchk(8'h08, 8'h10);
        @(posedge hclk) ien <= 8'h81;
        ifl <= 8'h01;
        cyc(1);
        chk({30'h0, sleeping, wdt_clr}, 32'h1);
        pulse(6'h20);
        cyc(0);
        chk({30'h0, sleeping, wdt_clr}, 32'h0);
        @(posedge hclk) ifl <= 8'h00;
        pulse(6'h20);
        pulse(6'h02);
        cyc(0);
        chk({30'h0, sleeping, wdt_clr}, 32'h1);
        @(posedge hclk) hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 8'h1C);
        rchk(8'h08, 8'h18);
        print_verdict();
    end
endmodule
`default_nettype wire

// File: sim/brsw_partner.sv
// Purpose: far side model: supply detector and external reset pin
// Assumes: commands change on hclk rising edges
// Notes: a disabled detector's supply_low toggles, it never holds a value; det_ready holds low
`timescale 1ns/1ps
`default_nettype none
module brsw_partner (
    input wire logic hclk,
    input wire logic det_enable,
    input wire logic low_cmd,
    input wire logic pin_cmd,
    output logic supply_low,
    output logic det_ready,
    output logic pin_n
);
    logic tog = 1'b0;
    logic [2:0] settle = 3'h0;
    // settling time after enable, restarts when switched off
    always @(posedge hclk) begin
        tog <= ~tog;
        settle <= det_enable ? settle + {2'h0, settle != 3'h4} : 3'h0;
    end
    assign supply_low = det_enable ? low_cmd : tog;
    assign det_ready = det_enable && settle == 3'h4;
    // pull-up on the pin: released reads high
    assign pin_n = ~pin_cmd;
endmodule
`default_nettype wire
